// file: aiac_top.sv
// analog input acquisition control with AXI4-Lite register access
// Summary of operation
// - any access to the soft-convert strobe starts one conversion
// - an active-low pulse on the convert pin starts one conversion
// - each finished conversion is pushed into the result FIFO automatically
// - status shows not-empty while at least one result is stored
// - reading FIFO data pops the oldest result; not-empty drops when drained
// - not-empty appears about 10 us after a conversion starts
// - a result arriving with 512 stored is dropped and sets sticky overflow
// - a start while converting sets the sticky overrun flag
// - the acquisition-clear strobe resets overflow and overrun
// - at acquisition end all counters reload so a new trigger restarts it
// - posttrigger counts from first trigger, pretrigger from the second
// - acquisition starts on start-register write or trigger pin falling edge
// - command registers update only the byte lanes enabled by write strobes and read back as zero
// - after reset FIFO empty, flags clear, acquisition idle
// - three internal counters serve interval, sample count and scan interval
// - scanning converts listed channels round-robin at sample interval spacing
// - interval scanning waits for the scan interval before repeating the list
// - acquisition clear also empties the FIFO and clears the done flag
`include "aiac_defines.svh"
module aiac_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_convert_n,
  input wire logic ext_acq_trigger_n,
  input wire logic [15:0] adc_data,
  output logic conv_start_pulse,
  output logic [3:0] conv_channel,
  output logic channel_list_clear_strobe,
  output logic acquisition_done_flag,
  output logic result_fifo_not_empty
);
  localparam int CONV_LAT = `AIAC_CONV_CYCLES;

  function automatic logic aiac_mapped(input logic [7:0] a);
    aiac_mapped = (a <= `AIAC_OFF_FIFO_DATA) && (a[1:0] == 2'h0);
  endfunction : aiac_mapped

  function automatic logic [15:0] aiac_merge(input logic [15:0] old_v,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    aiac_merge = {strb[1] ? data[15:8] : old_v[15:8], strb[0] ? data[7:0] : old_v[7:0]};
  endfunction : aiac_merge

  aiac_fifo_if fifo_bus ();
  logic ext_conv_fell, ext_trig_fell;

  aiac_fifo u_fifo (.aclk(aclk), .aresetn(aresetn), .bus(fifo_bus.store));
  aiac_sync_edge u_conv_sync (.aclk(aclk), .aresetn(aresetn), .pin_n(ext_convert_n),
                              .fell_pulse(ext_conv_fell));
  aiac_sync_edge u_trig_sync (.aclk(aclk), .aresetn(aresetn), .pin_n(ext_acq_trigger_n),
                              .fell_pulse(ext_trig_fell));

  // bus slave state
  logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic do_wr, do_rd;
  logic [15:0] cmd_q [4];
  logic [15:0] cmd_d [4];
  logic chclr_q, chclr_d;

  // converter, flags and acquisition state
  logic [15:0] adc_s1_q, adc_s2_q;
  logic conv_busy_q, conv_busy_d, conv_start_q, conv_start_d;
  logic [9:0] conv_cnt_q, conv_cnt_d;
  logic [3:0] conv_chan_q, conv_chan_d;
  logic overflow_q, overflow_d, overrun_q, overrun_d, done_q, done_d;
  aiac_pkg::acq_state_t st_q, st_d;
  logic counting_q, counting_d;
  logic [15:0] int_cnt_q, int_cnt_d, samp_cnt_q, samp_cnt_d, scan_cnt_q, scan_cnt_d;
  logic [3:0] chan_q, chan_d;
  logic soft_conv, clr, acq_start_wr, trig, samp_tick, start_req, push_req, list_end;
  logic [5:0] status;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign status = {st_q != aiac_pkg::ST_IDLE, conv_busy_q, done_q, overrun_q, overflow_q,
                   fifo_bus.not_empty};

  always_comb
  begin
    aw_have_d = aw_have_q;
    awaddr_d = awaddr_q;
    w_have_d = w_have_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    cmd_d = cmd_q;
    do_wr = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (aw_have_q && w_have_q && !bvalid_q)
    begin
      do_wr = 1'b1;
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = aiac_mapped(awaddr_q) ? `AIAC_RESP_OKAY : `AIAC_RESP_DECERR;
      if (aiac_mapped(awaddr_q) && awaddr_q < `AIAC_OFF_SOFT_CONV)
        cmd_d[awaddr_q[3:2]] = aiac_merge(cmd_q[awaddr_q[3:2]], wdata_q, wstrb_q);
    end
    else if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
  end

  // a read answers in the next cycle; FIFO head is taken as it pops
  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    do_rd = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      do_rd = 1'b1;
      rvalid_d = 1'b1;
      rresp_d = aiac_mapped(s_axi_araddr) ? `AIAC_RESP_OKAY : `AIAC_RESP_DECERR;
      case (s_axi_araddr)
        `AIAC_OFF_STATUS: rdata_d = {26'h0, status};
        `AIAC_OFF_FIFO_DATA: rdata_d = {16'h0, fifo_bus.head};
        default: rdata_d = 32'h0;
      endcase
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
  end

  always_comb
  begin
    soft_conv = (do_wr && awaddr_q == `AIAC_OFF_SOFT_CONV) ||
                (do_rd && s_axi_araddr == `AIAC_OFF_SOFT_CONV);
    clr = (do_wr && awaddr_q == `AIAC_OFF_ACQ_CLEAR) ||
          (do_rd && s_axi_araddr == `AIAC_OFF_ACQ_CLEAR);
    acq_start_wr = do_wr && awaddr_q == `AIAC_OFF_ACQ_START;
    chclr_d = (do_wr && awaddr_q == `AIAC_OFF_CHLIST_CLR) ||
              (do_rd && s_axi_araddr == `AIAC_OFF_CHLIST_CLR);
    trig = acq_start_wr || ext_trig_fell;
    samp_tick = (st_q == aiac_pkg::ST_ACTIVE) && (int_cnt_q == 16'h0000);
    start_req = soft_conv || ext_conv_fell || samp_tick;
    push_req = conv_busy_q && (conv_cnt_q == 10'h000);
    fifo_bus.push = push_req;
    fifo_bus.push_data = adc_s2_q;
    fifo_bus.pop = do_rd && s_axi_araddr == `AIAC_OFF_FIFO_DATA;
    fifo_bus.flush = clr;
    conv_busy_d = conv_busy_q;
    conv_cnt_d = conv_cnt_q;
    conv_chan_d = conv_chan_q;
    conv_start_d = 1'b0;
    if (conv_busy_q)
    begin
      if (push_req)
        conv_busy_d = 1'b0;
      else
        conv_cnt_d = conv_cnt_q - 10'h001;
    end
    // a start during a conversion is not executed, only flagged
    if (start_req && !conv_busy_q)
    begin
      conv_busy_d = 1'b1;
      conv_start_d = 1'b1;
      conv_cnt_d = 10'(CONV_LAT - 1);
      conv_chan_d = chan_q;
    end
    // set beats clear so no error is lost
    overrun_d = (start_req && conv_busy_q) ? 1'b1 : (clr ? 1'b0 : overrun_q);
    overflow_d = (push_req && fifo_bus.full) ? 1'b1 : (clr ? 1'b0 : overflow_q);
  end

  // counters: int_cnt sample interval, samp_cnt sample count, scan_cnt scan interval
  always_comb
  begin
    st_d = st_q;
    counting_d = counting_q;
    int_cnt_d = int_cnt_q;
    samp_cnt_d = samp_cnt_q;
    scan_cnt_d = scan_cnt_q;
    chan_d = chan_q;
    done_d = clr ? 1'b0 : done_q;
    list_end = !cmd_q[0][`AIAC_CMD1_SCAN_EN] ||
               chan_q == cmd_q[0][`AIAC_CMD1_LAST_MSB:`AIAC_CMD1_LAST_LSB];
    if (st_q != aiac_pkg::ST_IDLE && scan_cnt_q != 16'h0000)
      scan_cnt_d = scan_cnt_q - 16'h0001;
    if (st_q != aiac_pkg::ST_IDLE && trig && !counting_q)
      counting_d = 1'b1;
    case (st_q)
      aiac_pkg::ST_IDLE:
      begin
        if (trig && cmd_q[0][`AIAC_CMD1_ACQ_EN])
        begin
          st_d = aiac_pkg::ST_ACTIVE;
          counting_d = !cmd_q[0][`AIAC_CMD1_PRETRIG];
          int_cnt_d = cmd_q[2];
          samp_cnt_d = cmd_q[1];
          scan_cnt_d = cmd_q[3];
          chan_d = 4'h0;
        end
      end
      aiac_pkg::ST_ACTIVE:
      begin
        int_cnt_d = samp_tick ? cmd_q[2] : int_cnt_q - 16'h0001;
        if (samp_tick)
        begin
          if (counting_q && samp_cnt_q == 16'h0000)
          begin
            st_d = aiac_pkg::ST_IDLE;
            done_d = 1'b1;
            int_cnt_d = cmd_q[2];
            samp_cnt_d = cmd_q[1];
            scan_cnt_d = cmd_q[3];
            chan_d = 4'h0;
          end
          else
          begin
            if (counting_q)
              samp_cnt_d = samp_cnt_q - 16'h0001;
            if (list_end)
            begin
              chan_d = 4'h0;
              if (cmd_q[0][`AIAC_CMD1_SCAN_EN] && cmd_q[0][`AIAC_CMD1_SCAN_INT_EN])
                st_d = aiac_pkg::ST_SCAN_WAIT;
            end
            else
              chan_d = chan_q + 4'h1;
          end
        end
      end
      aiac_pkg::ST_SCAN_WAIT:
      begin
        if (scan_cnt_q == 16'h0000)
        begin
          st_d = aiac_pkg::ST_ACTIVE;
          scan_cnt_d = cmd_q[3];
          int_cnt_d = cmd_q[2];
        end
      end
      default: st_d = aiac_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      rdata_q <= 32'h0;
      bresp_q <= `AIAC_RESP_OKAY;
      rresp_q <= `AIAC_RESP_OKAY;
      cmd_q <= '{default: `AIAC_CMD_RST};
      chclr_q <= 1'b0;
      adc_s1_q <= 16'h0000;
      adc_s2_q <= 16'h0000;
      conv_busy_q <= 1'b0;
      conv_start_q <= 1'b0;
      conv_cnt_q <= 10'h000;
      conv_chan_q <= 4'h0;
      overflow_q <= 1'b0;
      overrun_q <= 1'b0;
      done_q <= 1'b0;
      st_q <= aiac_pkg::ST_IDLE;
      counting_q <= 1'b0;
      int_cnt_q <= 16'h0000;
      samp_cnt_q <= 16'h0000;
      scan_cnt_q <= 16'h0000;
      chan_q <= 4'h0;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      rdata_q <= rdata_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      cmd_q <= cmd_d;
      chclr_q <= chclr_d;
      adc_s1_q <= adc_data;
      adc_s2_q <= adc_s1_q;
      conv_busy_q <= conv_busy_d;
      conv_start_q <= conv_start_d;
      conv_cnt_q <= conv_cnt_d;
      conv_chan_q <= conv_chan_d;
      overflow_q <= overflow_d;
      overrun_q <= overrun_d;
      done_q <= done_d;
      st_q <= st_d;
      counting_q <= counting_d;
      int_cnt_q <= int_cnt_d;
      samp_cnt_q <= samp_cnt_d;
      scan_cnt_q <= scan_cnt_d;
      chan_q <= chan_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign conv_start_pulse = conv_start_q;
  assign conv_channel = conv_chan_q;
  assign channel_list_clear_strobe = chclr_q;
  assign acquisition_done_flag = done_q;
  assign result_fifo_not_empty = fifo_bus.not_empty;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_conv_accept;
    start_req && !conv_busy_q;
  endsequence
  sequence s_acq_last;
    samp_tick && counting_q && samp_cnt_q == 16'h0000;
  endsequence

  a_conv_latency: assert property (
    s_conv_accept |-> ##[CONV_LAT:CONV_LAT] push_req)
    else $error("conversion result not pushed 10 us after start");
  a_soft_start: assert property (
    soft_conv && !conv_busy_q |=> conv_start_pulse && conv_busy_q)
    else $error("soft strobe did not start a conversion");
  a_ext_start: assert property (
    ext_conv_fell && !conv_busy_q |=> conv_start_pulse)
    else $error("convert pin pulse did not start a conversion");
  a_overrun_set: assert property (
    start_req && conv_busy_q |=> overrun_q && !conv_start_pulse)
    else $error("start during conversion not flagged");
  a_flags_sticky: assert property (
    (overflow_q || overrun_q) && !clr |=> $stable({overflow_q, overrun_q}) || $rose(overrun_q)
      || $rose(overflow_q))
    else $error("error flag dropped without a clear");
  a_clear_all: assert property (
    clr && !start_req && !push_req |=> !overrun_q && !overflow_q && !done_q
      && !result_fifo_not_empty)
    else $error("acquisition clear left state behind");
  a_trig_start: assert property (
    st_q == aiac_pkg::ST_IDLE && trig && cmd_q[0][`AIAC_CMD1_ACQ_EN] |=>
      st_q == aiac_pkg::ST_ACTIVE && counting_q == !$past(cmd_q[0][`AIAC_CMD1_PRETRIG]))
    else $error("trigger did not start acquisition");
  a_pre_hold: assert property (
    samp_tick && !counting_q |=> samp_cnt_q == $past(samp_cnt_q))
    else $error("sample count moved before the second trigger");
  a_acq_reload: assert property (
    s_acq_last |=> st_q == aiac_pkg::ST_IDLE && done_q && samp_cnt_q == $past(cmd_q[1])
      && int_cnt_q == $past(cmd_q[2]))
    else $error("counters not reloaded at acquisition end");
  a_cmd_unread: assert property (
    do_rd && s_axi_araddr < `AIAC_OFF_SOFT_CONV |=> s_axi_rvalid && s_axi_rdata == 32'h0)
    else $error("command register read back nonzero");
endmodule : aiac_top

// file: aiac_defines.svh
// register offsets, field positions, reset values and timing counts of the acquisition block
`ifndef AIAC_DEFINES_SVH
`define AIAC_DEFINES_SVH

`define AIAC_OFF_CMD1 8'h00
`define AIAC_OFF_CMD2 8'h04
`define AIAC_OFF_CMD3 8'h08
`define AIAC_OFF_CMD4 8'h0C
`define AIAC_OFF_SOFT_CONV 8'h10
`define AIAC_OFF_ACQ_CLEAR 8'h14
`define AIAC_OFF_ACQ_START 8'h18
`define AIAC_OFF_CHLIST_CLR 8'h1C
`define AIAC_OFF_STATUS 8'h20
`define AIAC_OFF_FIFO_DATA 8'h24

`define AIAC_CMD1_ACQ_EN 0
`define AIAC_CMD1_PRETRIG 1
`define AIAC_CMD1_SCAN_EN 2
`define AIAC_CMD1_SCAN_INT_EN 3
`define AIAC_CMD1_LAST_MSB 7
`define AIAC_CMD1_LAST_LSB 4

`define AIAC_CMD_RST 16'h0000
`define AIAC_SYNC_RST 1'b1

`define AIAC_RESP_OKAY 2'h0
`define AIAC_RESP_DECERR 2'h3

`define AIAC_DATA_W 16
`define AIAC_FIFO_DEPTH 512
`define AIAC_FIFO_AW 9
`define AIAC_FIFO_FULL 10'h200

`define AIAC_CONV_TIME_NS 10000
`define AIAC_CLK_PERIOD_NS 20
`define AIAC_CONV_CYCLES ((`AIAC_CONV_TIME_NS + `AIAC_CLK_PERIOD_NS - 1) / `AIAC_CLK_PERIOD_NS)

`endif

// file: aiac_pkg.sv
// types shared by the acquisition block
package aiac_pkg;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_SCAN_WAIT = 2'b10
  } acq_state_t;
endpackage : aiac_pkg

// file: aiac_fifo_if.sv
// link between the controller and the result store
`include "aiac_defines.svh"
interface aiac_fifo_if;
  logic push;
  logic [`AIAC_DATA_W-1:0] push_data;
  logic pop;
  logic flush;
  logic full;
  logic not_empty;
  logic [`AIAC_DATA_W-1:0] head;
  modport ctrl (output push, output push_data, output pop, output flush,
                input full, input not_empty, input head);
  modport store (input push, input push_data, input pop, input flush,
                 output full, output not_empty, output head);
endinterface : aiac_fifo_if

// file: aiac_sync_edge.sv
// two-stage synchroniser with falling-edge detect for an active-low pin
`include "aiac_defines.svh"
module aiac_sync_edge (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_n,
  output logic fell_pulse
);
  logic s1_q, s2_q, s3_q;
  logic s1_d, s2_d, s3_d;

  always_comb
  begin
    s1_d = pin_n;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q <= `AIAC_SYNC_RST;
      s2_q <= `AIAC_SYNC_RST;
      s3_q <= `AIAC_SYNC_RST;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  // only stage two and three are looked at
  assign fell_pulse = s3_q & ~s2_q;

  a_single_pulse: assert property (
    @(posedge aclk) disable iff (!aresetn) fell_pulse |=> !fell_pulse)
    else $error("edge detect gave a pulse longer than one cycle");
endmodule : aiac_sync_edge

// file: aiac_fifo.sv
// result store, 512 words of flip-flops
`include "aiac_defines.svh"
module aiac_fifo (
  input wire logic aclk,
  input wire logic aresetn,
  aiac_fifo_if.store bus
);
  logic [`AIAC_DATA_W-1:0] mem_q [`AIAC_FIFO_DEPTH];
  logic [`AIAC_FIFO_AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [`AIAC_FIFO_AW:0] count_q, count_d;
  logic do_push, do_pop;

  // flush beats a push in the same cycle so a clear leaves it truly empty
  always_comb
  begin
    do_push = bus.push && !bus.full && !bus.flush;
    do_pop = bus.pop && bus.not_empty && !bus.flush;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d = count_q;
    if (bus.flush)
    begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
      count_d = '0;
    end
    else
    begin
      if (do_push)
        wr_ptr_d = wr_ptr_q + 1'b1;
      if (do_pop)
        rd_ptr_d = rd_ptr_q + 1'b1;
      if (do_push && !do_pop)
        count_d = count_q + 1'b1;
      else if (do_pop && !do_push)
        count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
    end
  end

  // storage needs no reset; the count guards it
  always_ff @(posedge aclk)
  begin
    if (do_push)
      mem_q[wr_ptr_q] <= bus.push_data;
  end

  assign bus.full = (count_q == `AIAC_FIFO_FULL);
  assign bus.not_empty = (count_q != '0);
  assign bus.head = mem_q[rd_ptr_q];

  a_pop_count: assert property (
    @(posedge aclk) disable iff (!aresetn)
    bus.pop && bus.not_empty && !bus.push && !bus.flush |=> count_q == $past(count_q) - 1'b1)
    else $error("read did not remove one result");
  a_full_drop: assert property (
    @(posedge aclk) disable iff (!aresetn)
    bus.push && bus.full && !bus.pop && !bus.flush |=> count_q == `AIAC_FIFO_FULL)
    else $error("result stored past the depth");
  a_push_visible: assert property (
    @(posedge aclk) disable iff (!aresetn)
    bus.push && !bus.full && !bus.flush |=> bus.not_empty)
    else $error("stored result not shown as present");
endmodule : aiac_fifo

// file: aiac_pin_model.sv
// far-side model: convert and trigger pins plus converter data
module aiac_pin_model (
  input wire logic aclk,
  input wire logic conv_req,
  input wire logic trig_req,
  input wire logic conv_start_pulse,
  output logic ext_convert_n,
  output logic ext_acq_trigger_n,
  output logic [15:0] adc_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] conv_cnt = 3'h0;
  logic [2:0] trig_cnt = 3'h0;
  initial adc_data = 16'hA000;
  // pulses stay low 4 cycles, longer than the pin synchroniser needs
  assign ext_convert_n = (conv_cnt == 3'h0);
  assign ext_acq_trigger_n = (trig_cnt == 3'h0);
  always @(posedge aclk)
  begin
    conv_cnt <= conv_req ? 3'h4 : (conv_cnt == 3'h0 ? 3'h0 : conv_cnt - 3'h1);
    trig_cnt <= trig_req ? 3'h4 : (trig_cnt == 3'h0 ? 3'h0 : trig_cnt - 3'h1);
    // new sample per conversion, held until the next start
    if (conv_start_pulse)
      adc_data <= adc_data + 16'h0001;
  end
endmodule : aiac_pin_model

// file: testbench.sv
// self-checking bench for the acquisition control block
`include "aiac_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, conv_req, trig_req, ext_convert_n, ext_acq_trigger_n, conv_start_pulse;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] adc_data, lfsr;
  logic result_fifo_not_empty, list_clr, done_pin;
  logic [3:0] conv_chan;
  logic [11:0] chan_hist;
  int error_cnt, comparisons, seq, n, iv, clr_seen, gap, per;

  aiac_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_convert_n, .ext_acq_trigger_n, .adc_data, .conv_start_pulse, .conv_channel(conv_chan),
    .channel_list_clear_strobe(list_clr), .acquisition_done_flag(done_pin),
    .result_fifo_not_empty);
  aiac_pin_model u_pins (.aclk, .conv_req, .trig_req, .conv_start_pulse, .ext_convert_n,
    .ext_acq_trigger_n, .adc_data);

  // strobe count, channel history and edges between the last two conversion starts
  always @(posedge aclk)
  begin
    gap <= conv_start_pulse ? 1 : gap + 1;
    if (conv_start_pulse)
    begin
      per <= gap;
      chan_hist <= {chan_hist[7:0], conv_chan};
    end
    if (list_clr) clr_seen <= clr_seen + 1;
  end

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  function automatic logic [15:0] next_lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : next_lfsr

  task automatic give_verdict;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic give_up;
    error_cnt++;
    $display("mismatch at %0t: wait timed out", $time);
    give_verdict();
  endtask : give_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one bus access; ready and answer sampled mid-cycle, released after the taking edge
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic aw_hs, w_hs, ar_hs, done;
    @(posedge aclk);
    if (wr)
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end
    else
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    for (int i = 0; i < 50; i++)
    begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      ar_hs = s_axi_arvalid && s_axi_arready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      if (done)
      begin
        chk({30'h0, wr ? s_axi_bresp : s_axi_rresp}, {30'h0, er}, "response");
        rd_q = s_axi_rdata;
      end
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      if (ar_hs) s_axi_arvalid <= 1'b0;
      if (done)
      begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    give_up();
  endtask : axi

  task automatic stat(input logic [3:0] exp);
    axi(1'b0, `AIAC_OFF_STATUS, 32'h0, `AIAC_RESP_OKAY);
    chk({28'h0, rd_q[3:0]}, {28'h0, exp}, "status");
    // pins looked at mid-cycle, where they are settled
    @(negedge aclk);
    chk({30'h0, done_pin, result_fifo_not_empty}, {30'h0, exp[3], exp[0]}, "flag pins");
  endtask : stat

  // results leave in start order; each start bumps the model's sample by one
  task automatic drain(input int cnt);
    repeat (cnt)
    begin
      axi(1'b0, `AIAC_OFF_FIFO_DATA, 32'h0, `AIAC_RESP_OKAY);
      chk({16'h0, rd_q[15:0]}, {16'h0, 16'hA001 + seq[15:0]}, "fifo data");
      seq++;
    end
  endtask : drain

  task automatic wait_ne;
    for (n = 0; n < 700; n++)
    begin
      @(negedge aclk);
      if (result_fifo_not_empty === 1'b1) return;
    end
    give_up();
  endtask : wait_ne

  task automatic pulse(input logic trig);
    @(posedge aclk);
    if (trig) trig_req <= 1'b1;
    else conv_req <= 1'b1;
    @(posedge aclk);
    trig_req <= 1'b0;
    conv_req <= 1'b0;
  endtask : pulse

  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {aresetn, conv_req, trig_req, error_cnt, comparisons, seq} = '0;
    lfsr = 16'hDCC0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++)
      axi(1'b1, `AIAC_OFF_CMD1 + 8'(4 * i), 32'h0, `AIAC_RESP_OKAY);
    axi(1'b1, `AIAC_OFF_CHLIST_CLR, 32'h0, `AIAC_RESP_OKAY);
    axi(1'b0, `AIAC_OFF_CHLIST_CLR, 32'h0, `AIAC_RESP_OKAY);
    axi(1'b0, `AIAC_OFF_ACQ_CLEAR, 32'h0, `AIAC_RESP_OKAY);
    chk(clr_seen, 32'h2, "list clear strobes");
    stat(4'h0);
    axi(1'b0, 8'h28, 32'h0, `AIAC_RESP_DECERR);
    lfsr = next_lfsr(lfsr);
    axi(1'b1, `AIAC_OFF_CMD2, {16'h0, lfsr}, `AIAC_RESP_OKAY);
    axi(1'b0, `AIAC_OFF_CMD2, 32'h0, `AIAC_RESP_OKAY);
    chk(rd_q, 32'h0, "command readback");
    axi(1'b1, `AIAC_OFF_SOFT_CONV, 32'h0, `AIAC_RESP_OKAY);
    wait_ne();
    chk(32'(n > 490 && n < 505), 32'h1, "fill delay");
    stat(4'h1);
    drain(1);
    stat(4'h0);
    // the read access is a second start while the first still converts
    axi(1'b1, `AIAC_OFF_SOFT_CONV, 32'h0, `AIAC_RESP_OKAY);
    axi(1'b0, `AIAC_OFF_SOFT_CONV, 32'h0, `AIAC_RESP_OKAY);
    wait_ne();
    stat(4'h5);
    drain(1);
    stat(4'h4);
    axi(1'b1, `AIAC_OFF_ACQ_CLEAR, 32'h0, `AIAC_RESP_OKAY);
    stat(4'h0);
    pulse(1'b0);
    wait_ne();
    axi(1'b0, `AIAC_OFF_ACQ_CLEAR, 32'h0, `AIAC_RESP_OKAY);
    stat(4'h0);
    seq++;
    pulse(1'b0);
    wait_ne();
    drain(1);
    stat(4'h0);
    // interval kept above the 500-cycle conversion so no overrun
    lfsr = next_lfsr(lfsr);
    iv = 520 + lfsr[7:0];
    axi(1'b1, `AIAC_OFF_CMD3, iv - 1, `AIAC_RESP_OKAY);
    axi(1'b1, `AIAC_OFF_CMD2, 32'h2, `AIAC_RESP_OKAY);
    axi(1'b1, `AIAC_OFF_CMD1, 32'h1, `AIAC_RESP_OKAY);
    axi(1'b1, `AIAC_OFF_ACQ_START, 32'h0, `AIAC_RESP_OKAY);
    repeat (4 * iv + 600) @(posedge aclk);
    stat(4'h9);
    drain(3);
    stat(4'h8);
    axi(1'b1, `AIAC_OFF_ACQ_CLEAR, 32'h0, `AIAC_RESP_OKAY);
    pulse(1'b1);
    repeat (4 * iv + 600) @(posedge aclk);
    stat(4'h9);
    drain(3);
    axi(1'b1, `AIAC_OFF_ACQ_CLEAR, 32'h0, `AIAC_RESP_OKAY);
    axi(1'b1, `AIAC_OFF_CMD1, 32'h3, `AIAC_RESP_OKAY);
    axi(1'b1, `AIAC_OFF_ACQ_START, 32'h0, `AIAC_RESP_OKAY);
    repeat (4 * iv + 600) @(posedge aclk);
    stat(4'h1);
    pulse(1'b1);
    repeat (4 * iv + 600) @(posedge aclk);
    stat(4'h9);
    // two-entry list with a scan interval of four sample intervals
    axi(1'b1, `AIAC_OFF_ACQ_CLEAR, 32'h0, `AIAC_RESP_OKAY);
    axi(1'b1, `AIAC_OFF_CMD4, 4 * iv, `AIAC_RESP_OKAY);
    axi(1'b1, `AIAC_OFF_CMD1, 32'h1D, `AIAC_RESP_OKAY);
    axi(1'b1, `AIAC_OFF_ACQ_START, 32'h0, `AIAC_RESP_OKAY);
    repeat (6 * iv + 600) @(posedge aclk);
    stat(4'h9);
    chk({20'h0, chan_hist}, 32'h010, "scan channels");
    chk(32'(per >= 3 * iv && per <= 3 * iv + 1), 32'h1, "scan wait");
    give_verdict();
  end
endmodule : testbench
